// *** ibp_pkg.sv ***
package ibp_pkg;
  // ----------------------------------------------------------------
  // register map (word offsets on the plain register port)
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_ARRAY_CONTROL  = 8'h00;
  localparam logic [7:0] ADDR_BACKEND_TWO    = 8'h01;
  localparam logic [7:0] ADDR_EXTREME_VALUE  = 8'h02;
  localparam logic [7:0] ADDR_EXCEED_COUNT   = 8'h03;
  localparam logic [7:0] ADDR_THRESHOLD      = 8'h04;
  localparam logic [7:0] ADDR_LUT_BASE       = 8'h40;
  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int LUT_ACCESS_BIT = 1;
  localparam int RECT_EN_BIT    = 0;
  localparam int RECT_HALF_BIT  = 1;
  localparam int MON_MODE_BIT   = 2;
  // ----------------------------------------------------------------
  // widths and reset values
  // ----------------------------------------------------------------
  localparam int ACC_W   = 22;
  localparam int CNT_W   = 16;
  localparam int LUT_DEPTH = 64;
  localparam logic [ACC_W-1:0] EXTREME_START = 22'h20_0000;
  localparam logic [CNT_W-1:0] CNT_MAX       = 16'hFFFF;
  localparam logic [7:0]       CTRL_RESET    = 8'h00;
endpackage

// *** ibp_lut.sv ***
`timescale 1ns/1ps
module ibp_lut
  import ibp_pkg::*;
(
  // clock
  input  wire logic        ref_clk,
  // host write port
  input  wire logic        wr_en,
  input  wire logic [5:0]  wr_addr,
  input  wire logic [31:0] wr_data,
  // shared read port
  input  wire logic [5:0]  rd_addr,
  output logic      [31:0] rd_word
);
  logic [31:0] table_mem [LUT_DEPTH];

  always_ff @(posedge ref_clk) begin
    if (wr_en) begin
      table_mem[wr_addr] <= wr_data;
    end
  end

  assign rd_word = table_mem[rd_addr];
endmodule

// *** ibp_backend.sv ***
// The register offsets and the strobed register port were decided locally.
`timescale 1ns/1ps
// What this block does
// - access bit 0 lets host write table; 1 lets datapath use it
// - input byte n is replaced by the byte stored at table location n
// - running-maximum mode keeps largest rectified result since last write
// - overshoot mode counts every output above the programmed threshold
// - overshoot counter saturates at its limit instead of wrapping
// - full-wave rectification replaces each result with its magnitude, except EXTREME_START (22'h20_0000), which passes unchanged
// - half-wave rectification is a selectable alternative to full-wave
// - table word is forced to zero while the access bit is 0
// - sixty-four 32-bit words; upper six bits word, lower two byte
module ibp_backend
  import ibp_pkg::*;
(
  // clock and reset
  input  wire logic             ref_clk,
  input  wire logic             rst,
  // accumulator stream
  input  wire logic [ACC_W-1:0] acc_data,
  input  wire logic             acc_valid,
  // register port
  input  wire logic [7:0]       reg_addr,
  input  wire logic [31:0]      reg_wdata,
  input  wire logic             reg_wr,
  input  wire logic             reg_rd,
  output logic      [31:0]      reg_rdata,
  // transformed output
  output logic      [7:0]       out_byte,
  output logic      [ACC_W-1:0] out_rect,
  output logic                  out_valid
);
  typedef enum logic {IBP_MAX, IBP_COUNT} ibp_mode_e;

  typedef struct packed {
    logic [7:0]       array_control_reg;
    logic [7:0]       backend_control_two;
    logic [ACC_W-1:0] extreme_value_register;
    logic [CNT_W-1:0] threshold_exceed_counter;
    logic [ACC_W-1:0] threshold;
    logic [31:0]      rdata;
    logic [7:0]       obyte;
    logic [ACC_W-1:0] orect;
    logic             ovalid;
  } ibp_state_s;

  ibp_state_s st;
  ibp_state_s next_st;

  logic             lut_use;
  logic [ACC_W-1:0] rect_val;
  logic [31:0]      lut_word;
  logic [31:0]      y_word;
  logic [5:0]       lut_rd_addr;
  logic             lut_wr;
  logic             lut_sel;
  ibp_mode_e        mon_mode;

  assign lut_use  = st.array_control_reg[LUT_ACCESS_BIT];
  assign mon_mode = st.backend_control_two[MON_MODE_BIT] ? IBP_COUNT : IBP_MAX;

  // ----------------------------------------------------------------
  // rectifier
  // ----------------------------------------------------------------
  always_comb begin
    rect_val = acc_data;
    if (st.backend_control_two[RECT_EN_BIT] && acc_data[ACC_W-1]) begin
      if (st.backend_control_two[RECT_HALF_BIT]) begin
        rect_val = '0;
      end else begin
        rect_val = ACC_W'(-$signed(acc_data));
      end
    end
  end

  // ----------------------------------------------------------------
  // lookup table
  // ----------------------------------------------------------------
  // host may only write while the datapath does not own the table
  // only 0x40-0x7f reach the table; higher addresses must not alias onto it
  assign lut_sel = reg_addr[7:6] == ADDR_LUT_BASE[7:6];
  assign lut_wr  = reg_wr && lut_sel && !lut_use;
  // datapath index: low byte of rectified result, word and byte lane
  assign lut_rd_addr = lut_use ? rect_val[7:2] : reg_addr[5:0];

  ibp_lut u_lut (
    .ref_clk (ref_clk),
    .wr_en   (lut_wr),
    .wr_addr (reg_addr[5:0]),
    .wr_data (reg_wdata),
    .rd_addr (lut_rd_addr),
    .rd_word (lut_word)
  );

  assign y_word = lut_use ? lut_word : 32'h0000_0000;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    next_st        = st;
    next_st.ovalid = acc_valid;
    if (acc_valid) begin
      next_st.orect = rect_val;
      next_st.obyte = y_word[8*rect_val[1:0] +: 8];
      case (mon_mode)
        IBP_MAX: begin
          if ($signed(rect_val) > $signed(st.extreme_value_register)) begin
            next_st.extreme_value_register = rect_val;
          end
        end
        IBP_COUNT: begin
          if ($signed(rect_val) > $signed(st.threshold) &&
              st.threshold_exceed_counter != CNT_MAX) begin
            next_st.threshold_exceed_counter =
              st.threshold_exceed_counter + 1'b1;
          end
        end
        default: begin
          next_st.ovalid = acc_valid;
        end
      endcase
    end
    // host writes come last so a fresh start value wins over an update
    if (reg_wr) begin
      case (reg_addr)
        ADDR_ARRAY_CONTROL: next_st.array_control_reg = reg_wdata[7:0];
        ADDR_BACKEND_TWO:   next_st.backend_control_two = reg_wdata[7:0];
        ADDR_EXTREME_VALUE:
          next_st.extreme_value_register = reg_wdata[ACC_W-1:0];
        ADDR_EXCEED_COUNT:
          next_st.threshold_exceed_counter = reg_wdata[CNT_W-1:0];
        ADDR_THRESHOLD:     next_st.threshold = reg_wdata[ACC_W-1:0];
        default: begin
          next_st.threshold = st.threshold;
        end
      endcase
    end
    next_st.rdata = 32'h0000_0000;
    if (reg_rd) begin
      case (reg_addr)
        ADDR_ARRAY_CONTROL:
          next_st.rdata = {24'h00_0000, st.array_control_reg};
        ADDR_BACKEND_TWO:
          next_st.rdata = {24'h00_0000, st.backend_control_two};
        ADDR_EXTREME_VALUE:
          next_st.rdata = 32'(signed'(st.extreme_value_register));
        ADDR_EXCEED_COUNT:
          next_st.rdata = {16'h0000, st.threshold_exceed_counter};
        ADDR_THRESHOLD:     next_st.rdata = {10'h000, st.threshold};
        default: begin
          // table readable by host only while it owns the table
          if (lut_sel && !lut_use) begin
            next_st.rdata = lut_word;
          end
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      st.array_control_reg        <= CTRL_RESET;
      st.backend_control_two      <= CTRL_RESET;
      st.extreme_value_register   <= EXTREME_START;
      st.threshold_exceed_counter <= '0;
      st.threshold                <= '0;
      st.rdata                    <= 32'h0000_0000;
      st.obyte                    <= 8'h00;
      st.orect                    <= '0;
      st.ovalid                   <= 1'b0;
    end else begin
      st <= next_st;
    end
  end

  assign reg_rdata = st.rdata;
  assign out_byte  = st.obyte;
  assign out_rect  = st.orect;
  assign out_valid = st.ovalid;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  a_max_never_drops: assert property (
    @(posedge ref_clk) disable iff (rst)
    !$past(reg_wr) && mon_mode == IBP_MAX && $past(mon_mode == IBP_MAX)
    |-> $signed(st.extreme_value_register) >=
        $signed($past(st.extreme_value_register)))
    else $error("running maximum decreased");

  a_max_strict_update: assert property (
    @(posedge ref_clk) disable iff (rst)
    acc_valid && !reg_wr && mon_mode == IBP_MAX &&
    $signed(rect_val) > $signed(st.extreme_value_register)
    |=> st.extreme_value_register == $past(rect_val))
    else $error("maximum not taken");

  a_count_step: assert property (
    @(posedge ref_clk) disable iff (rst)
    acc_valid && !reg_wr && mon_mode == IBP_COUNT &&
    $signed(rect_val) > $signed(st.threshold) &&
    st.threshold_exceed_counter != CNT_MAX
    |=> st.threshold_exceed_counter ==
        $past(st.threshold_exceed_counter) + 1'b1)
    else $error("overshoot not counted");

  a_count_saturate: assert property (
    @(posedge ref_clk) disable iff (rst)
    st.threshold_exceed_counter == CNT_MAX && !reg_wr
    |=> st.threshold_exceed_counter == CNT_MAX)
    else $error("counter wrapped");

  a_rect_full: assert property (
    @(posedge ref_clk) disable iff (rst)
    acc_valid && st.backend_control_two[RECT_EN_BIT] &&
    !st.backend_control_two[RECT_HALF_BIT]
    |=> !out_rect[ACC_W-1] || out_rect == EXTREME_START)
    else $error("full-wave gave negative");

  a_rect_half: assert property (
    @(posedge ref_clk) disable iff (rst)
    acc_valid && st.backend_control_two[RECT_EN_BIT] &&
    st.backend_control_two[RECT_HALF_BIT] && acc_data[ACC_W-1]
    |=> out_rect == '0)
    else $error("half-wave passed negative");

  a_lut_zeroed: assert property (
    @(posedge ref_clk) disable iff (rst)
    acc_valid && !lut_use |=> out_byte == 8'h00 && out_valid)
    else $error("table output not forced to zero");

  a_lut_locked: assert property (
    @(posedge ref_clk) disable iff (rst)
    lut_use |-> !lut_wr)
    else $error("table written while in use");

  a_lut_read_locked: assert property (
    @(posedge ref_clk) disable iff (rst)
    lut_use && reg_rd && lut_sel |=> reg_rdata == 32'h0000_0000)
    else $error("table readable while in use");
endmodule

// *** ibp_acc_src.sv ***
`timescale 1ns/1ps
// stand-in for the multiply-accumulate array
module ibp_acc_src
  import ibp_pkg::*;
(
  // clock and reset
  input  wire logic             ref_clk,
  input  wire logic             rst,
  // sample request from the bench
  input  wire logic             go,
  input  wire logic [ACC_W-1:0] val,
  // accumulator stream
  output logic      [ACC_W-1:0] acc_data,
  output logic                  acc_valid
);
  // idle data flips every cycle so stale samples never look valid
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      acc_valid <= 1'b0;
      acc_data  <= '0;
    end else begin
      acc_valid <= go;
      acc_data  <= go ? val : ~acc_data;
    end
  end
endmodule

// *** test_image_backend_postprocessor.sv ***
`timescale 1ns/1ps
module test_image_backend_postprocessor
  import ibp_pkg::*;
;
  logic                    ref_clk = 0, rst = 1, go = 0;
  logic                    reg_wr = 0, reg_rd = 0, rd_d = 0;
  logic                    acc_valid, out_valid, lut_on = 0;
  logic [ACC_W-1:0]        val = '0, acc_data, out_rect;
  logic [7:0]              reg_addr = '0, out_byte;
  logic [31:0]             reg_wdata = '0, reg_rdata, s = 32'h0001_8038;
  logic [31:0]             lut [LUT_DEPTH];
  logic [29:0]             sq [$];
  logic [31:0]             rq [$];
  logic [29:0]             e;
  logic [2:0]              cfg = '0;
  logic signed [ACC_W-1:0] mx, thr;
  logic [CNT_W-1:0]        cnt;
  int                      mismatches = 0, n_compared = 0;

  always #10 ref_clk = ~ref_clk;

  ibp_acc_src i_src (.ref_clk(ref_clk), .rst(rst), .go(go), .val(val),
    .acc_data(acc_data), .acc_valid(acc_valid));
  ibp_backend i_dut (.ref_clk(ref_clk), .rst(rst), .acc_data(acc_data),
    .acc_valid(acc_valid), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .out_byte(out_byte), .out_rect(out_rect), .out_valid(out_valid));

  // ------------------------------------------------------------
  // bus, stream and scoreboard
  // ------------------------------------------------------------
  task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH %s exp %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic wr(logic [7:0] a, logic [31:0] d);
    @(posedge ref_clk);
    reg_wr    <= 1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 0;
  endtask

  task automatic rd(logic [7:0] a, logic [31:0] x);
    rq.push_back(x);
    @(posedge ref_clk);
    reg_rd   <= 1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 0;
  endtask

  // model follows the current setup; samples go out back to back
  task automatic run(int n);
    logic signed [ACC_W-1:0] v, r;
    for (int i = 0; i < n; i++) begin
      s = s ^ (s << 13);
      s = s ^ (s >> 17);
      s = s ^ (s << 5);
      v = s[ACC_W-1:0];
      if (n == 1) v = 22'h00_0005;
      r = (!cfg[0] || !v[ACC_W-1]) ? v : cfg[1] ? '0 : -v;
      if (cfg[2] && r > thr && cnt != CNT_MAX) cnt++;
      if (!cfg[2] && r > mx) mx = r;
      sq.push_back({r, lut_on ? lut[r[7:2]][8*r[1:0] +: 8] : 8'h00});
      @(posedge ref_clk);
      go  <= 1;
      val <= v;
    end
    @(posedge ref_clk);
    go <= 0;
    repeat (3) @(posedge ref_clk);
  endtask

  always @(posedge ref_clk) begin
    rd_d <= reg_rd;
    if (rd_d) chk("reg_rdata", reg_rdata, rq.pop_front());
    if (out_valid) begin
      e = sq.pop_front();
      chk("out_rect", 32'(out_rect), 32'(e[29:8]));
      chk("out_byte", 32'(out_byte), 32'(e[7:0]));
    end
  end

  task automatic print_verdict;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  // ------------------------------------------------------------
  // tests
  // ------------------------------------------------------------
  initial begin
    repeat (20) @(posedge ref_clk);
    rst <= 0;
    mx  = EXTREME_START;
    cnt = '0;
    thr = '0;
    rd(ADDR_ARRAY_CONTROL, 0);
    rd(ADDR_EXTREME_VALUE, 32'hFFE0_0000);
    rd(ADDR_EXCEED_COUNT, 0);
    rd(8'h10, 0);
    $display("test reset done");
    for (int n = 0; n < LUT_DEPTH; n++) begin
      for (int k = 0; k < 4; k++)
        lut[n][8*k +: 8] = (4*n+k > 100) ? 8'h01 : 8'h00;
      wr(ADDR_LUT_BASE + 8'(n), lut[n]);
    end
    rd(ADDR_LUT_BASE + 8'd25, lut[25]);
    cfg = 3'b001;
    wr(ADDR_BACKEND_TWO, 1);
    run(4);
    lut_on = 1;
    wr(ADDR_ARRAY_CONTROL, 2);
    wr(ADDR_EXTREME_VALUE, 32'hFFE0_0000);
    mx = EXTREME_START;
    run(40);
    rd(ADDR_EXTREME_VALUE, 32'(mx));
    $display("test full wave done");
    cfg = 3'b011;
    wr(ADDR_BACKEND_TWO, 3);
    run(20);
    rd(ADDR_EXTREME_VALUE, 32'(mx));
    cfg = 3'b100;
    thr = 22'h3F_0000;
    wr(ADDR_BACKEND_TWO, 4);
    wr(ADDR_THRESHOLD, 32'hFFFF_0000);
    for (int j = 0; j < 2; j++) begin
      cnt = j ? 16'hFFF8 : 16'h0000;
      wr(ADDR_EXCEED_COUNT, 32'(cnt));
      run(30);
      rd(ADDR_EXCEED_COUNT, 32'(cnt));
    end
    $display("test counter done");
    wr(ADDR_LUT_BASE + 8'd1, 32'hFFFF_FFFF);
    rd(ADDR_LUT_BASE + 8'd1, 0);
    cfg = 3'b000;
    wr(ADDR_BACKEND_TWO, 0);
    run(1);
    chk("out_valid", 32'(sq.size()), 32'h0000_0000);
    $display("test table lock done");
    print_verdict();
  end

  initial begin
    repeat (5000) @(posedge ref_clk);
    mismatches++;
    print_verdict();
  end
endmodule
